// >>> src/oscillator_source_select.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module oscillator_source_select
    import osc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire reg_req_s            reg_req,
    output logic      [DATA_W-1:0]   rd_data,
    input  wire osc_lines_s          osc_lines,
    input  wire straps_s             straps,
    input  wire logic                halt_req,
    input  wire logic [PORT_W-1:0]   port_a_dir,
    output logic                     sys_clk_out,
    output logic                     wdt_clk_out,
    output logic                     timebase_clk_out,
    output logic                     ext_fast_crystal_en,
    output logic                     ext_rc_source_en,
    output logic                     int_fast_rc_en,
    output logic      [1:0]          int_fast_rc_freq,
    output logic                     int_slow_rc_en,
    output logic                     slow_crystal_en,
    output logic                     slow_crystal_low_power,
    output logic                     port_a_pin6_gpio,
    output logic                     port_a_pin5_gpio,
    output logic                     slow_xtal_pins_gpio,
    output logic      [PORT_W-1:0]   port_a_pullup_en
);

    localparam int SYNC_W = $bits(osc_lines_s) + $bits(straps_s);

    // Oscillator lines and straps come from outside this clock domain.
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    osc_lines_s        osc_s;
    straps_s           straps_s_w;

    // These flops carry no reset on purpose: the chain must already hold
    // the straps when reset lets go, because the straps are captured at
    // the first edge after it.
    always_ff @(posedge clk) begin
        sync1_reg <= {osc_lines, straps};
        sync2_reg <= sync1_reg;
    end

    assign {osc_s, straps_s_w} = sync2_reg;

    // Straps are captured once, after reset has been released.
    logic    cfg_done_reg;
    straps_s straps_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_done_reg <= 1'b0;
            straps_reg   <= STRAPS_RESET;
        end else if (!cfg_done_reg) begin
            cfg_done_reg <= 1'b1;
            straps_reg   <= straps_s_w;
        end
    end

    wire osc_cfg_e cfg_w     = straps_reg.cfg;
    wire is_xtal_w   = cfg_done_reg && cfg_w == CFG_EXT_CRYSTAL;
    wire is_erc_w    = cfg_done_reg && cfg_w == CFG_EXT_RC;
    wire is_int_fast_rc_w   = cfg_done_reg && cfg_w == CFG_INT_RC;
    wire paired_w    = cfg_done_reg && cfg_w == CFG_INT_RC_SLOW_XTAL;
    wire uses_int_fast_rc_w = is_int_fast_rc_w || paired_w;

    // Register file.
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [DATA_W-1:0] pullup_reg;
    logic [DATA_W-1:0] pullup_next;
    logic [DATA_W-1:0] rd_next;
    logic [DATA_W-1:0] status_w;

    wire wr_ctrl_w   = reg_req.wr && reg_req.addr == REG_CTRL;
    wire wr_pullup_w = reg_req.wr && reg_req.addr == REG_PULLUP;

    assign ctrl_next   = wr_ctrl_w ? (reg_req.wdata & CTRL_MASK) : ctrl_reg;
    assign pullup_next = wr_pullup_w ? reg_req.wdata : pullup_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg   <= CTRL_RESET;
            pullup_reg <= PULLUP_RESET;
            rd_data    <= READ_IDLE;
        end else begin
            ctrl_reg   <= ctrl_next;
            pullup_reg <= pullup_next;
            rd_data    <= rd_next;
        end
    end

    // Select bit only counts in the paired configuration.
    wire want_slow_w = paired_w && ctrl_reg[CTRL_SEL_BIT];

    // Fast source follows the configuration choice.
    wire fast_src_w = is_xtal_w ? osc_s.ext_fast_crystal :
                      is_erc_w  ? osc_s.ext_rc_source :
                      osc_s.int_fast_rc;
    wire slow_src_w = osc_s.slow_crystal;

    // Glitch-free switch: a source is dropped only while its level is low
    // and the other is taken only once the first is dropped and the new
    // one is low, so no high phase is ever cut.
    logic fast_on_reg;
    logic slow_on_reg;
    logic fast_on_next;
    logic slow_on_next;
    logic run_reg;
    logic run_next;

    assign fast_on_next = cfg_done_reg && (want_slow_w ?
        (fast_on_reg && fast_src_w) :
        (fast_on_reg || (!slow_on_reg && !fast_src_w)));
    assign slow_on_next = want_slow_w ?
        (slow_on_reg || (!fast_on_reg && !slow_src_w)) :
        (slow_on_reg && slow_src_w);

    wire mux_w = (fast_on_reg && fast_src_w) || (slow_on_reg && slow_src_w);

    // Halt gate also moves only on a low level of the selected clock.
    // Limitation: an oscillator that stops while high keeps the gate shut
    // until it runs again, so the analog cells must come to rest low.
    // Waking is then delayed by at most one high phase of the source.
    assign run_next = mux_w ? run_reg : !halt_req;
    wire halted_w   = halt_req && !run_reg;

    logic sys_next;
    logic wdt_next;
    logic tb_next;

    assign sys_next = run_reg && mux_w;
    // The watchdog keeps its own clock through a halt; only when the slow
    // RC is strapped off does it fall back to the gated system clock.
    assign wdt_next = int_slow_rc_en ? osc_s.int_slow_rc : sys_next;
    assign tb_next  = paired_w ? slow_src_w : wdt_next;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fast_on_reg      <= 1'b0;
            slow_on_reg      <= 1'b0;
            run_reg          <= 1'b0;
            sys_clk_out      <= 1'b0;
            wdt_clk_out      <= 1'b0;
            timebase_clk_out <= 1'b0;
        end else begin
            fast_on_reg      <= fast_on_next;
            slow_on_reg      <= slow_on_next;
            run_reg          <= run_next;
            sys_clk_out      <= sys_next;
            wdt_clk_out      <= wdt_next;
            timebase_clk_out <= tb_next;
        end
    end

    // Oscillator enables and pin sharing.
    wire fast_rc_stop_w = want_slow_w && !fast_on_reg;
    // Code 3 is unused and falls back to the slowest setting.
    wire [1:0] freq_w = (straps_reg.fast_rc_freq == FREQ_12MHZ ||
                         straps_reg.fast_rc_freq == FREQ_8MHZ) ?
                        straps_reg.fast_rc_freq : FREQ_4MHZ;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_fast_crystal_en    <= 1'b0;
            ext_rc_source_en       <= 1'b0;
            int_fast_rc_en         <= 1'b0;
            int_fast_rc_freq       <= FREQ_4MHZ;
            int_slow_rc_en         <= 1'b0;
            slow_crystal_en        <= 1'b0;
            slow_crystal_low_power <= 1'b0;
            port_a_pin6_gpio       <= 1'b0;
            port_a_pin5_gpio       <= 1'b0;
            slow_xtal_pins_gpio    <= 1'b0;
        end else begin
            ext_fast_crystal_en    <= is_xtal_w && !halted_w;
            ext_rc_source_en       <= is_erc_w && !halted_w;
            int_fast_rc_en         <= uses_int_fast_rc_w && !halted_w &&
                                      !fast_rc_stop_w;
            int_fast_rc_freq       <= freq_w;
            int_slow_rc_en         <= cfg_done_reg &&
                                      !straps_reg.slow_rc_off;
            slow_crystal_en        <= paired_w;
            slow_crystal_low_power <= paired_w &&
                                      ctrl_reg[CTRL_LP_BIT];
            port_a_pin6_gpio       <= is_int_fast_rc_w;
            port_a_pin5_gpio       <= is_int_fast_rc_w || is_erc_w;
            slow_xtal_pins_gpio    <= cfg_done_reg && !paired_w;
        end
    end

    // Pull-ups act only on pins set as inputs.
    genvar i;
    generate
        for (i = 0; i < PORT_W; i++) begin : g_pull
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    port_a_pullup_en[i] <= 1'b0;
                end else begin
                    port_a_pullup_en[i] <= pullup_reg[i] &&
                                           port_a_dir[i];
                end
            end
        end
    endgenerate

    // Read path; unmapped addresses return zero.
    always_comb begin
        status_w = '0;
        status_w[ST_CFG_LSB +: 2]  = cfg_w;
        status_w[ST_FREQ_LSB +: 2] = freq_w;
        status_w[ST_INT_SLOW_RC_OFF]      = straps_reg.slow_rc_off;
        status_w[ST_FAST_ON]       = fast_on_reg;
        status_w[ST_SLOW_ON]       = slow_on_reg;
        status_w[ST_HALTED]        = !run_reg;
    end

    assign rd_next = !reg_req.rd                 ? READ_IDLE :
                     reg_req.addr == REG_CTRL    ? ctrl_reg :
                     reg_req.addr == REG_PULLUP  ? pullup_reg :
                     reg_req.addr == REG_STATUS  ? status_w : READ_IDLE;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    lp_bit_reset_a : assert property (
        $rose(rst_b) |-> ##1 !slow_crystal_low_power)
        else $error("low-power bit not clear after reset");

    lp_bit_follow_a : assert property (
        paired_w && wr_ctrl_w ##1 paired_w |=>
        slow_crystal_low_power == $past(reg_req.wdata[CTRL_LP_BIT], 2))
        else $error("low-power output does not follow written bit");

    int_fast_rc_pins_gpio_a : assert property (
        is_int_fast_rc_w |=> port_a_pin6_gpio && port_a_pin5_gpio)
        else $error("pins not released for internal fast RC");

    erc_pin_use_a : assert property (
        is_erc_w |=> !port_a_pin6_gpio && port_a_pin5_gpio)
        else $error("wrong pin sharing for external RC");

    slow_xtal_pair_a : assert property (
        slow_crystal_en |-> $past(paired_w))
        else $error("slow crystal enabled outside paired setup");

    xtal_io_opt_a : assert property (
        cfg_done_reg && !paired_w |=> slow_xtal_pins_gpio)
        else $error("slow crystal pins not GPIO");

    timebase_xtal_a : assert property (
        paired_w |=> timebase_clk_out == $past(slow_src_w))
        else $error("time base lost slow crystal clock");

    halt_stops_a : assert property (
        halt_req && !mux_w ##1 halt_req |=> !sys_clk_out)
        else $error("system clock runs while halted");

    int_slow_rc_off_a : assert property (
        straps_reg.slow_rc_off |=> !int_slow_rc_en)
        else $error("slow RC enabled despite strap");

    wdt_source_a : assert property (
        int_slow_rc_en |=> wdt_clk_out == $past(osc_s.int_slow_rc))
        else $error("watchdog clock not from slow RC");

    pullup_gate_a : assert property (
        ##1 port_a_pullup_en == $past(pullup_reg & port_a_dir))
        else $error("pull-up enable wrong");

    int_fast_rc_stop_a : assert property (
        want_slow_w && !fast_on_reg |=> !int_fast_rc_en)
        else $error("fast RC still on after switch to slow");

    one_source_a : assert property (
        !(fast_on_reg && slow_on_reg))
        else $error("both clock sources gated on");

    // The output lags the gate by one register, so the cycle in which a
    // source is dropped must already show a low clock.
    no_cut_pulse_a : assert property (
        $fell(fast_on_reg) || $fell(slow_on_reg) |-> !sys_clk_out)
        else $error("clock source dropped during high phase");

endmodule // oscillator_source_select

// >>> src/osc_pkg.sv
package osc_pkg;

    // Oscillator pair chosen by the factory configuration straps.
    typedef enum logic [1:0] {
        CFG_EXT_CRYSTAL,
        CFG_EXT_RC,
        CFG_INT_RC,
        CFG_INT_RC_SLOW_XTAL
    } osc_cfg_e;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PULLUP = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;

    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_LP_BIT  = 1;
    localparam logic [DATA_W-1:0] CTRL_MASK    = 8'h03;
    localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] PULLUP_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE    = 8'h00;

    localparam int ST_CFG_LSB  = 0;
    localparam int ST_FREQ_LSB = 2;
    localparam int ST_INT_SLOW_RC_OFF = 4;
    localparam int ST_FAST_ON  = 5;
    localparam int ST_SLOW_ON  = 6;
    localparam int ST_HALTED   = 7;

    localparam logic [1:0] FREQ_4MHZ  = 2'h0;
    localparam logic [1:0] FREQ_8MHZ  = 2'h1;
    localparam logic [1:0] FREQ_12MHZ = 2'h2;

    localparam int FAST_RC_4_HZ  = 4_000_000;
    localparam int FAST_RC_8_HZ  = 8_000_000;
    localparam int FAST_RC_12_HZ = 12_000_000;
    localparam int SLOW_XTAL_HZ  = 32768;
    localparam int SLOW_RC_HZ    = 13000;

    typedef struct packed {
        osc_cfg_e   cfg;
        logic [1:0] fast_rc_freq;
        logic       slow_rc_off;
    } straps_s;

    localparam straps_s STRAPS_RESET = '{CFG_EXT_CRYSTAL, FREQ_4MHZ, 1'b0};

    // Raw oscillator outputs coming from the analog cells.
    typedef struct packed {
        logic ext_fast_crystal;
        logic ext_rc_source;
        logic int_fast_rc;
        logic slow_crystal;
        logic int_slow_rc;
    } osc_lines_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

endpackage

// >>> test/oscillator_source_select_bench.sv
`timescale 1ns/10ps
module oscillator_source_select_bench;
    import osc_pkg::*;
    localparam int FAST_HALF  = 2;
    localparam int SLOW_HALF  = 7;
    localparam int INT_SLOW_RC_HALF  = 11;
    localparam int MAX_CYCLES = 3000;

    logic              clk        = 1'b0;
    logic              rst_b      = 1'b0;
    reg_req_s          reg_req    = '0;
    osc_lines_s        osc_lines  = '0;
    straps_s           straps     = STRAPS_RESET;
    logic              halt_req   = 1'b0;
    logic [PORT_W-1:0] port_a_dir = '0;
    logic [DATA_W-1:0] rd_data;
    logic [PORT_W-1:0] port_a_pullup_en;
    logic [1:0]        int_fast_rc_freq;
    logic              sys_clk_out, wdt_clk_out, timebase_clk_out;
    logic              ext_fast_crystal_en, ext_rc_source_en;
    logic              int_fast_rc_en, int_slow_rc_en, slow_crystal_en;
    logic              slow_crystal_low_power, slow_xtal_pins_gpio;
    logic              port_a_pin6_gpio, port_a_pin5_gpio;
    logic [15:0]       exp_q[$];
    logic [15:0]       note;
    logic              rd_seen    = 1'b0;
    int                bad_count  = 0;
    int                num_checks = 0;
    int                cycles     = 0;
    int                osc_count  = 0;
    int                hi_run     = 0;
    int                fast_runs  = 0;
    int                slow_runs  = 0;
    wire logic [7:0]   cfg_outs   = {ext_fast_crystal_en, ext_rc_source_en,
        int_fast_rc_en, int_slow_rc_en, slow_crystal_en, port_a_pin6_gpio,
        port_a_pin5_gpio, slow_xtal_pins_gpio};

    oscillator_source_select dut_u (
        .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
        .osc_lines(osc_lines), .straps(straps), .halt_req(halt_req),
        .port_a_dir(port_a_dir), .sys_clk_out(sys_clk_out),
        .wdt_clk_out(wdt_clk_out), .timebase_clk_out(timebase_clk_out),
        .ext_fast_crystal_en(ext_fast_crystal_en),
        .ext_rc_source_en(ext_rc_source_en), .int_fast_rc_en(int_fast_rc_en),
        .int_fast_rc_freq(int_fast_rc_freq), .int_slow_rc_en(int_slow_rc_en),
        .slow_crystal_en(slow_crystal_en),
        .slow_crystal_low_power(slow_crystal_low_power),
        .port_a_pin6_gpio(port_a_pin6_gpio),
        .port_a_pin5_gpio(port_a_pin5_gpio),
        .slow_xtal_pins_gpio(slow_xtal_pins_gpio),
        .port_a_pullup_en(port_a_pullup_en)
    );

    always #25 clk = ~clk;

    // Oscillators move in whole clock cycles so every pulse length is exact.
    always @(posedge clk) begin
        osc_count <= osc_count + 1;
        osc_lines.ext_fast_crystal <= ((osc_count / FAST_HALF) % 2) == 1;
        osc_lines.ext_rc_source <= ((osc_count / FAST_HALF) % 2) == 1;
        osc_lines.int_fast_rc <= ((osc_count / FAST_HALF) % 2) == 1;
        osc_lines.slow_crystal <= ((osc_count / SLOW_HALF) % 2) == 1;
        osc_lines.int_slow_rc <= ((osc_count / INT_SLOW_RC_HALF) % 2) == 1;
        rd_seen <= reg_req.rd;
        cycles++;
        if (cycles == MAX_CYCLES) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want,
                         input string what);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %0t %s: saw %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            check(rd_data & note[15:8], note[7:0], "read");
        end else begin
            check(rd_data, READ_IDLE, "idle read");
        end
        // A shortened high pulse at a switch point shows up as a run of neither FAST_HALF nor SLOW_HALF cycles.
        if (!rst_b) begin
            hi_run = 0;
        end else if (sys_clk_out === 1'b1) begin
            hi_run++;
        end else if (hi_run != 0) begin
            fast_runs += int'(hi_run == FAST_HALF);
            slow_runs += int'(hi_run == SLOW_HALF);
            check({7'h0, hi_run == FAST_HALF || hi_run == SLOW_HALF}, 8'h01,
                  "pulse");
            hi_run = 0;
        end
    end

    task automatic bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic w, input logic r);
        reg_req <= '{a, d, w, r};
        @(posedge clk);
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] want,
                            input logic [DATA_W-1:0] mask);
        exp_q.push_back({mask, want & mask});
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic idle(input int n);
        reg_req <= '0;
        repeat (n) @(posedge clk);
    endtask

    task automatic restart(input osc_cfg_e c, input logic [1:0] f,
                           input logic off);
        straps     <= '{c, f, off};
        rst_b      <= 1'b0;
        reg_req    <= '0;
        halt_req   <= 1'b0;
        port_a_dir <= 8'($urandom);
        repeat (7) @(posedge clk);
        @(negedge clk);
        check(cfg_outs, 8'h00, "reset enables");
        check({sys_clk_out, slow_crystal_low_power, 6'h0}, 8'h00,
              "reset");
        @(posedge clk);
        rst_b <= 1'b1;
        idle(16);
    endtask

    initial begin
        logic [7:0] pull, junk, st;
        logic [1:0] feff;
        logic       off;
        int         seen [5];
        void'($urandom(32'h02F2C2EA));
        for (int c = 0; c < 4; c++) begin
            for (int f = 0; f < 4; f++) begin
                off  = 1'($urandom);
                feff = (f == 3) ? FREQ_4MHZ : 2'(f);
                st   = {3'h0, off, feff, 2'(c)};
                pull = 8'($urandom);
                junk = 8'($urandom);
                restart(osc_cfg_e'(c), 2'(f), off);
                @(negedge clk);
                check(cfg_outs, {c == 0, c == 1, c >= 2, !off, c == 3, c == 2,
                      c == 1 || c == 2, c != 3},
                      "sources");
                check({6'h0, int_fast_rc_freq}, {6'h0, feff}, "freq");
                @(posedge clk);
                reg_read(REG_STATUS, st, 8'h9F);
                reg_read(REG_CTRL, CTRL_RESET, 8'hFF);
                reg_read(REG_PULLUP, PULLUP_RESET, 8'hFF);
                bus(REG_CTRL, 8'hFF, 1'b1, 1'b0);
                reg_read(REG_CTRL, CTRL_MASK, 8'hFF);
                bus(REG_PULLUP, pull, 1'b1, 1'b0);
                bus(4'(3 + junk % 13), junk, 1'b1, 1'b0);
                bus(REG_STATUS, ~junk, 1'b1, 1'b0);
                reg_read(4'(3 + junk % 13), READ_IDLE, 8'hFF);
                reg_read(REG_STATUS, st, 8'h1F);
                reg_read(REG_PULLUP, pull, 8'hFF);
                idle(2);
                @(negedge clk);
                check({7'h0, slow_crystal_low_power}, {7'h0, c == 3}, "lp");
                check(port_a_pullup_en, pull & port_a_dir, "pullup");
                @(posedge clk);
                bus(REG_CTRL, 8'h00, 1'b1, 1'b0);
                idle(3);
                @(negedge clk);
                check({7'h0, slow_crystal_low_power}, 8'h00, "lp off");
                @(posedge clk);
            end
        end
        restart(CFG_INT_RC_SLOW_XTAL, FREQ_8MHZ, 1'b0);
        // Low power is only asked for once the slow crystal has started.
        bus(REG_CTRL, 8'h03, 1'b1, 1'b0);
        idle(40);
        reg_read(REG_STATUS, 8'h40, 8'h60);
        idle(1);
        @(negedge clk);
        check({int_fast_rc_en, slow_crystal_en, slow_crystal_low_power, 5'h0},
              8'h60, "slow mode");
        @(posedge clk);
        bus(REG_CTRL, 8'h00, 1'b1, 1'b0);
        idle(40);
        halt_req <= 1'b1;
        idle(20);
        reg_read(REG_STATUS, 8'hA0, 8'hE0);
        idle(1);
        seen = '{default: 0};
        repeat (40) begin
            @(negedge clk);
            seen[0] += int'(sys_clk_out !== 1'b0);
            seen[1] += int'(wdt_clk_out === 1'b1);
            seen[2] += int'(wdt_clk_out === 1'b0);
            seen[3] += int'(timebase_clk_out === 1'b1);
            seen[4] += int'(timebase_clk_out === 1'b0);
        end
        check({7'h0, seen[0] == 0}, 8'h01, "halted clock");
        check({6'h0, seen[1] > 0 && seen[2] > 0, seen[3] > 0 && seen[4] > 0},
              8'h03, "side clocks");
        check({int_fast_rc_en, int_slow_rc_en, 6'h0}, 8'h40, "halt");
        @(posedge clk);
        halt_req <= 1'b0;
        idle(40);
        @(negedge clk);
        check({7'h0, int_fast_rc_en}, 8'h01, "wake");
        check({6'h0, fast_runs > 0, slow_runs > 0}, 8'h03, "runs");
        tally_and_finish();
    end
endmodule // oscillator_source_select_bench
